// [core/rkc_defines.svh]
// Register offsets, field positions, reset values and timing counts of the remote key logic.
`ifndef RKC_DEFINES_SVH
`define RKC_DEFINES_SVH

`define RKC_CLK_KHZ 125000
`define RKC_SHIFT_TIME_MS 2000
`define RKC_STOP_TIME_MS 5000
`define RKC_SPEED_STEP_MS 10
`define RKC_SHIFT_CYC (`RKC_SHIFT_TIME_MS * `RKC_CLK_KHZ)
`define RKC_STOP_CYC (`RKC_STOP_TIME_MS * `RKC_CLK_KHZ)
`define RKC_SPEED_STEP_CYC (`RKC_SPEED_STEP_MS * `RKC_CLK_KHZ)

`define RKC_PRESET_SMALL 32'h0000_0064
`define RKC_PRESET_LARGE 32'h0000_03e8

`define RKC_OFS_CTRL 4'h0
`define RKC_OFS_STATUS 4'h4
`define RKC_OFS_PRESET 4'h8
`define RKC_OFS_SPEED 4'hc

`define RKC_CTRL_MENU_CLOSE 0
`define RKC_ST_MENU 0
`define RKC_ST_SHIFT 1
`define RKC_ST_PRESET 2
`define RKC_ST_START 3
`define RKC_ST_STOP 4
`define RKC_ST_FLOW 5

`define RKC_IDLE_RESET 8'h20
`define RKC_SPEED_MAX 8'hff
`define RKC_PRESET_RESET 32'h0000_c350

`define RKC_RESP_OKAY 2'h0
`define RKC_RESP_SLVERR 2'h2

`endif

// [core/rkc_pkg.sv]
// Types shared by the remote key command logic.
package rkc_pkg;

   typedef logic [7:0] rkc_speed_t;
   typedef logic [31:0] rkc_word_t;

   // Key order inside the packed key vector.
   typedef enum logic [3:0] {
      RKC_K_START = 4'h0,
      RKC_K_STOP = 4'h1,
      RKC_K_ESTOP = 4'h2,
      RKC_K_UP = 4'h3,
      RKC_K_DOWN = 4'h4,
      RKC_K_VUP = 4'h5,
      RKC_K_VDN = 4'h6,
      RKC_K_MENU = 4'h7,
      RKC_K_SHIFT = 4'h8
   } rkc_key_t;

   typedef enum logic [1:0] {
      RKC_WR_IDLE = 2'b01,
      RKC_WR_RESP = 2'b10
   } rkc_wr_state_t;

   typedef struct packed {
      logic [8:0] prev_keys;
      logic shift_on;
      rkc_word_t shift_cnt;
      logic start_hold;
      rkc_word_t stop_cnt;
      rkc_speed_t speed;
      rkc_speed_t idle_speed;
      rkc_word_t step_cnt;
      rkc_word_t preset;
      logic preset_send;
      logic menu_open;
      logic discharge_stop;
      logic aw_got;
      logic [3:0] aw_addr;
      logic w_got;
      rkc_word_t w_data;
      logic [3:0] w_strb;
      rkc_wr_state_t wr_state;
      logic [1:0] b_resp;
      logic r_valid;
      rkc_word_t r_data;
      logic [1:0] r_resp;
   } rkc_state_t;

endpackage : rkc_pkg

// [core/rkc_remote_keys.sv]
// Key command interpreter of the hand-held remote with its register slave.
`timescale 1ns/1ns
`include "rkc_defines.svh"

// Behaviour
// - Menu opens only idle and host-linked
// - Shift softkey toggles shift, shown on display
// - Shifted command needs shift then key
// - Shift expires after two seconds
// - Preset screen volume press adds two seconds
// - Shift clears on reshift, or on shifted start or stop with no preset volume press in that cycle
// - Motor start follows held start key
// - Motor start resets speed to idle unless a speed step lands in that cycle
// - Discharge start ignores motor state
// - Motor stop is fixed five-second pulse
// - Emergency stop ends discharge and stops motor
// - Flow switch lets speed keys ramp speed
// - Without flow switch speed stays idle
// - Motor stop accepted at any speed
// - Plain volume key steps preset 100 litres
// - Shifted volume key steps 1000 litres
// - Key preset changes sent to host immediately
// - Host preset screen switches remote preset screen
// - Softkey labels shown only when available
module rkc_remote_keys #(
   parameter int unsigned SHIFT_CYC = `RKC_SHIFT_CYC,
   parameter int unsigned STOP_CYC = `RKC_STOP_CYC,
   parameter int unsigned SPEED_STEP_CYC = `RKC_SPEED_STEP_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic key_start,
   input wire logic key_stop,
   input wire logic key_estop,
   input wire logic key_speed_up,
   input wire logic key_speed_down,
   input wire logic key_vol_up,
   input wire logic key_vol_down,
   input wire logic menu_softkey,
   input wire logic shift_softkey,
   input wire logic flow_switch,
   input wire logic host_link_ok,
   input wire logic discharge_active,
   input wire logic host_preset_screen,
   output logic motor_start,
   output logic motor_stop,
   output logic discharge_stop,
   output rkc_pkg::rkc_speed_t engine_speed,
   output logic menu_open,
   output logic shift_upper,
   output logic label_menu,
   output logic label_shift,
   output logic preset_screen,
   output rkc_pkg::rkc_word_t preset_volume,
   output logic preset_send,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import rkc_pkg::*;

   localparam rkc_word_t SHIFT_LEN = rkc_word_t'(SHIFT_CYC);
   localparam rkc_word_t STOP_LEN = rkc_word_t'(STOP_CYC);
   localparam rkc_word_t STEP_LEN = rkc_word_t'(SPEED_STEP_CYC);

   rkc_state_t cur;
   rkc_state_t nxt;
   logic [8:0] keys;
   logic [8:0] rise;
   logic shift_press;
   logic shifted;
   logic vol_press;
   logic is_preset;
   logic menu_avail;
   logic st_rd_ok;
   rkc_word_t status_word;

   // Byte-lane merge of a write into a stored word.
   function automatic rkc_word_t merge_bytes(input rkc_word_t old, input rkc_word_t data, input logic [3:0] strb);
      rkc_word_t res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   // Saturating add; the shift extension and the preset both must never wrap.
   function automatic rkc_word_t sat_add(input rkc_word_t a, input rkc_word_t b);
      logic [32:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[32] ? 32'hffff_ffff : s[31:0];
   endfunction : sat_add

   function automatic rkc_word_t sat_sub(input rkc_word_t a, input rkc_word_t b);
      return (a > b) ? a - b : 32'h0000_0000;
   endfunction : sat_sub

   // Preset step size: the large step applies while shift is active.
   function automatic rkc_word_t preset_step(input logic big);
      return big ? `RKC_PRESET_LARGE : `RKC_PRESET_SMALL;
   endfunction : preset_step

   always_comb begin
      keys = {shift_softkey, menu_softkey, key_vol_down, key_vol_up, key_speed_down,
              key_speed_up, key_estop, key_stop, key_start};
      rise = keys & ~cur.prev_keys;
      is_preset = host_preset_screen;
      menu_avail = !discharge_active && host_link_ok && !cur.menu_open;
      // A key counts as shifted only when shift was already on and the shift key is no longer down,
      // so pressing both together never forms a shifted command.
      shifted = cur.shift_on && !shift_softkey;
      shift_press = rise[RKC_K_SHIFT] && !cur.menu_open && (keys[7:0] == 8'h00);
      vol_press = is_preset && (rise[RKC_K_VUP] || rise[RKC_K_VDN]);
      status_word = 32'h0000_0000;
      status_word[`RKC_ST_MENU] = cur.menu_open;
      status_word[`RKC_ST_SHIFT] = cur.shift_on;
      status_word[`RKC_ST_PRESET] = is_preset;
      status_word[`RKC_ST_START] = cur.start_hold;
      status_word[`RKC_ST_STOP] = (cur.stop_cnt != 32'h0000_0000);
      status_word[`RKC_ST_FLOW] = flow_switch;

      nxt = cur;
      nxt.prev_keys = keys;
      nxt.preset_send = 1'b0;
      nxt.discharge_stop = 1'b0;

      // Shift state and its timeout.
      if (cur.shift_on) begin
         if (cur.shift_cnt <= 32'h0000_0001) begin
            nxt.shift_on = 1'b0;
            nxt.shift_cnt = 32'h0000_0000;
         end else begin
            nxt.shift_cnt = cur.shift_cnt - 32'h0000_0001;
         end
      end
      if (shift_press) begin
         nxt.shift_on = !cur.shift_on;
         nxt.shift_cnt = cur.shift_on ? 32'h0000_0000 : SHIFT_LEN;
      end

      // Motor start and stop.
      if (shifted && rise[RKC_K_START]) begin
         nxt.start_hold = 1'b1;
         nxt.speed = cur.idle_speed;
         nxt.shift_on = 1'b0;
      end else if (!key_start) begin
         nxt.start_hold = 1'b0;
      end
      if (cur.stop_cnt != 32'h0000_0000) begin
         nxt.stop_cnt = cur.stop_cnt - 32'h0000_0001;
      end
      // Stop is taken regardless of speed; a stop also cancels any start still held.
      if (shifted && rise[RKC_K_STOP]) begin
         nxt.stop_cnt = STOP_LEN;
         nxt.start_hold = 1'b0;
         nxt.shift_on = 1'b0;
      end else if (rise[RKC_K_STOP]) begin
         nxt.discharge_stop = 1'b1;
      end
      if (rise[RKC_K_ESTOP]) begin
         nxt.discharge_stop = 1'b1;
         nxt.stop_cnt = STOP_LEN;
         nxt.start_hold = 1'b0;
      end

      // Engine speed ramp under the flow switch.
      if (!flow_switch) begin
         nxt.speed = cur.idle_speed;
         nxt.step_cnt = 32'h0000_0000;
      end else if (key_speed_up ^ key_speed_down) begin
         if (cur.step_cnt >= STEP_LEN - 32'h0000_0001) begin
            nxt.step_cnt = 32'h0000_0000;
            if (key_speed_up && cur.speed != `RKC_SPEED_MAX) begin
               nxt.speed = cur.speed + 8'h01;
            end else if (key_speed_down && cur.speed > cur.idle_speed) begin
               nxt.speed = cur.speed - 8'h01;
            end
         end else begin
            nxt.step_cnt = cur.step_cnt + 32'h0000_0001;
         end
      end else begin
         nxt.step_cnt = 32'h0000_0000;
      end

      // Preset stepping in the preset screen.
      if (vol_press) begin
         if (cur.shift_on) begin
            nxt.shift_on = 1'b1;
            nxt.shift_cnt = sat_add(cur.shift_cnt, SHIFT_LEN);
         end
         if (rise[RKC_K_VUP]) begin
            nxt.preset = sat_add(cur.preset, preset_step(cur.shift_on));
         end else begin
            nxt.preset = sat_sub(cur.preset, preset_step(cur.shift_on));
         end
         nxt.preset_send = 1'b1;
      end

      // Menu softkey; a running discharge closes an open menu.
      if (rise[RKC_K_MENU] && menu_avail) begin
         nxt.menu_open = 1'b1;
         nxt.shift_on = 1'b0;
      end else if (discharge_active || !host_link_ok) begin
         nxt.menu_open = 1'b0;
      end

      // Write channel: address and data are taken in either order.
      if (cur.wr_state == RKC_WR_IDLE) begin
         if (s_axi_awvalid && !cur.aw_got) begin
            nxt.aw_got = 1'b1;
            nxt.aw_addr = s_axi_awaddr;
         end
         if (s_axi_wvalid && !cur.w_got) begin
            nxt.w_got = 1'b1;
            nxt.w_data = s_axi_wdata;
            nxt.w_strb = s_axi_wstrb;
         end
         if (cur.aw_got && cur.w_got) begin
            nxt.aw_got = 1'b0;
            nxt.w_got = 1'b0;
            nxt.wr_state = RKC_WR_RESP;
            nxt.b_resp = `RKC_RESP_OKAY;
            case (cur.aw_addr)
               `RKC_OFS_CTRL: begin
                  // An operator opening the menu in the same cycle wins over the software close.
                  if (cur.w_strb[0] && cur.w_data[`RKC_CTRL_MENU_CLOSE] && !(rise[RKC_K_MENU] && menu_avail)) begin
                     nxt.menu_open = 1'b0;
                  end
               end
               `RKC_OFS_STATUS: begin
               end
               `RKC_OFS_PRESET: begin
                  // A local key step in the same cycle wins over the software load.
                  if (!vol_press) begin
                     nxt.preset = merge_bytes(cur.preset, cur.w_data, cur.w_strb);
                  end
               end
               `RKC_OFS_SPEED: begin
                  if (cur.w_strb[1]) begin
                     nxt.idle_speed = cur.w_data[15:8];
                  end
               end
               default: begin
                  nxt.b_resp = `RKC_RESP_SLVERR;
               end
            endcase
         end
      end else begin
         if (s_axi_bready) begin
            nxt.wr_state = RKC_WR_IDLE;
         end
      end

      // Read channel.
      st_rd_ok = 1'b1;
      if (!cur.r_valid && s_axi_arvalid) begin
         nxt.r_valid = 1'b1;
         case (s_axi_araddr)
            `RKC_OFS_CTRL: nxt.r_data = 32'h0000_0000;
            `RKC_OFS_STATUS: nxt.r_data = status_word;
            `RKC_OFS_PRESET: nxt.r_data = cur.preset;
            `RKC_OFS_SPEED: nxt.r_data = {16'h0000, cur.idle_speed, cur.speed};
            default: begin
               nxt.r_data = 32'h0000_0000;
               st_rd_ok = 1'b0;
            end
         endcase
         nxt.r_resp = st_rd_ok ? `RKC_RESP_OKAY : `RKC_RESP_SLVERR;
      end else if (cur.r_valid && s_axi_rready) begin
         nxt.r_valid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cur <= '0;
         cur.idle_speed <= `RKC_IDLE_RESET;
         cur.speed <= `RKC_IDLE_RESET;
         cur.preset <= `RKC_PRESET_RESET;
         cur.wr_state <= RKC_WR_IDLE;
      end else begin
         cur <= nxt;
      end
   end

   // Discharge start is left entirely to the host, so nothing here looks at motor state for it.
   assign motor_start = cur.start_hold;
   assign motor_stop = (cur.stop_cnt != 32'h0000_0000);
   assign discharge_stop = cur.discharge_stop;
   assign engine_speed = cur.speed;
   assign menu_open = cur.menu_open;
   assign shift_upper = cur.shift_on;
   assign label_menu = !discharge_active && host_link_ok && !cur.menu_open;
   assign label_shift = !cur.menu_open;
   assign preset_screen = host_preset_screen;
   assign preset_volume = cur.preset;
   assign preset_send = cur.preset_send;
   assign s_axi_awready = (cur.wr_state == RKC_WR_IDLE) && !cur.aw_got;
   assign s_axi_wready = (cur.wr_state == RKC_WR_IDLE) && !cur.w_got;
   assign s_axi_bvalid = (cur.wr_state == RKC_WR_RESP);
   assign s_axi_bresp = cur.b_resp;
   assign s_axi_arready = !cur.r_valid;
   assign s_axi_rvalid = cur.r_valid;
   assign s_axi_rdata = cur.r_data;
   assign s_axi_rresp = cur.r_resp;

endmodule : rkc_remote_keys

// [testbench/rkc_host_model.sv]
// Behavioural model of the metering host on the far side of the remote.
`timescale 1ns/1ns
module rkc_host_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic want_link,
   input wire logic want_dis,
   input wire logic want_scr,
   input wire logic preset_send,
   input wire rkc_pkg::rkc_word_t preset_volume,
   output logic host_link_ok,
   output logic discharge_active,
   output logic host_preset_screen,
   output rkc_pkg::rkc_word_t rx_preset
);
   import rkc_pkg::*;
   initial {host_link_ok, discharge_active, host_preset_screen} = 3'h0;
   // The host reports one clock late, as a real link partner would.
   always @(posedge aclk) begin
      if (!aresetn) begin
         host_link_ok <= 1'b0;
         discharge_active <= 1'b0;
         host_preset_screen <= 1'b0;
         rx_preset <= 32'h0;
      end else begin
         host_link_ok <= want_link;
         discharge_active <= want_dis;
         host_preset_screen <= want_scr;
         if (preset_send) rx_preset <= preset_volume;
      end
   end
endmodule : rkc_host_model

// [testbench/rkc_remote_keys_asserts.sv]
// Concurrent checks on the ports of the remote key command logic.
`timescale 1ns/1ns
`include "rkc_defines.svh"
module rkc_remote_keys_chk #(
   parameter int unsigned STOP_CYC = 50
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic key_start,
   input wire logic key_estop,
   input wire logic key_vol_up,
   input wire logic key_vol_down,
   input wire logic flow_switch,
   input wire logic host_link_ok,
   input wire logic discharge_active,
   input wire logic host_preset_screen,
   input wire logic motor_start,
   input wire logic motor_stop,
   input wire logic discharge_stop,
   input wire rkc_pkg::rkc_speed_t engine_speed,
   input wire logic menu_open,
   input wire logic label_shift,
   input wire logic preset_screen,
   input wire logic preset_send
);
   import rkc_pkg::*;
   int unsigned stop_run;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Counts how long the stop output has stood, so the pulse length is checked exactly.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stop_run <= 0;
      end else begin
         stop_run <= motor_stop ? stop_run + 1 : 0;
      end
   end
   a_menu_gate: assert property ($rose(menu_open) |-> $past(host_link_ok) && !$past(discharge_active))
      else $error("menu opened while busy or unlinked");
   a_label_shift: assert property (label_shift == !menu_open)
      else $error("shift label wrong");
   a_start_held: assert property (motor_start |-> key_start || $past(key_start))
      else $error("motor start without held key");
   a_stop_len: assert property ($fell(motor_stop) |-> stop_run == STOP_CYC)
      else $error("stop pulse length wrong");
   a_stop_max: assert property (stop_run <= STOP_CYC)
      else $error("stop pulse too long");
   a_estop_both: assert property ($rose(key_estop) |-> ##[1:3] discharge_stop ##[0:2] motor_stop)
      else $error("emergency stop incomplete");
   a_speed_idle: assert property ($past(!flow_switch) |-> engine_speed == `RKC_IDLE_RESET)
      else $error("speed not idle without flow");
   a_preset_follow: assert property (preset_screen == host_preset_screen)
      else $error("preset screen not following host");
   a_send_cause: assert property (preset_send |-> $past(key_vol_up) || $past(key_vol_down)
      || $past(key_vol_up, 2) || $past(key_vol_down, 2))
      else $error("preset send without volume key");
   cover property ($rose(motor_start));
   cover property ($rose(menu_open));
   cover property ($fell(motor_stop));
   cover property (preset_send);
endmodule : rkc_remote_keys_chk

bind rkc_remote_keys rkc_remote_keys_chk #(.STOP_CYC(STOP_CYC)) i_rkc_remote_keys_chk (.aclk, .aresetn,
   .key_start, .key_estop, .key_vol_up, .key_vol_down, .flow_switch, .host_link_ok, .discharge_active,
   .host_preset_screen, .motor_start, .motor_stop, .discharge_stop, .engine_speed, .menu_open,
   .label_shift, .preset_screen, .preset_send);

// [testbench/rkc_remote_keys_bench.sv]
// Self-checking bench of the remote key command logic.
`timescale 1ns/1ns
`include "rkc_defines.svh"
module rkc_remote_keys_bench;
   import rkc_pkg::*;
   localparam int unsigned SC = 20;
   localparam int unsigned PC = 50;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [8:0] keys = 9'h0;
   logic flow_switch = 1'b0;
   logic want_link = 1'b0, want_dis = 1'b0, want_scr = 1'b0;
   logic host_link_ok, discharge_active, host_preset_screen, motor_start, motor_stop, discharge_stop;
   logic menu_open, shift_upper, label_menu, label_shift, preset_screen, preset_send;
   rkc_speed_t engine_speed;
   rkc_word_t preset_volume, rx_preset;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #4 aclk = ~aclk;
   rkc_remote_keys #(.SHIFT_CYC(SC), .STOP_CYC(PC), .SPEED_STEP_CYC(4)) i_rkc_remote_keys (.aclk, .aresetn,
      .key_start(keys[0]), .key_stop(keys[1]), .key_estop(keys[2]), .key_speed_up(keys[3]),
      .key_speed_down(keys[4]), .key_vol_up(keys[5]), .key_vol_down(keys[6]), .menu_softkey(keys[7]),
      .shift_softkey(keys[8]), .flow_switch, .host_link_ok, .discharge_active, .host_preset_screen,
      .motor_start, .motor_stop, .discharge_stop, .engine_speed, .menu_open, .shift_upper, .label_menu,
      .label_shift, .preset_screen, .preset_volume, .preset_send, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   rkc_host_model i_rkc_host_model (.aclk, .aresetn, .want_link, .want_dis, .want_scr, .preset_send,
      .preset_volume, .host_link_ok, .discharge_active, .host_preset_screen, .rx_preset);
   task automatic close_out;
      if (err_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         close_out;
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask : tick
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic press(input rkc_key_t k);
      keys[k] <= 1'b1;
      tick(3);
      keys[k] <= 1'b0;
      tick(3);
   endtask : press
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", 32'h0, {30'h0, s_axi_bresp});
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rresp", 32'h0, {30'h0, s_axi_rresp});
      chk("rdata", e, s_axi_rdata);
   endtask : rd
   task automatic t_menu;
      want_link <= 1'b1;
      tick(3);
      chk("label_menu", 32'h1, label_menu);
      press(RKC_K_MENU);
      chk("menu_open", 32'h1, menu_open);
      chk("label_shift", 32'h0, label_shift);
      wr(`RKC_OFS_CTRL, 32'h1);
      chk("menu_open", 32'h0, menu_open);
      // Let the host report the running discharge before the key comes.
      want_dis <= 1'b1;
      tick(2);
      press(RKC_K_MENU);
      chk("menu_open", 32'h0, menu_open);
      chk("label_menu", 32'h0, label_menu);
      want_dis <= 1'b0;
      tick(2);
   endtask : t_menu
   task automatic t_stop;
      flow_switch <= 1'b1;
      keys[RKC_K_UP] <= 1'b1;
      tick(24);
      keys[RKC_K_UP] <= 1'b0;
      tick(1);
      chk("speed_up", 32'h1, engine_speed > `RKC_IDLE_RESET);
      press(RKC_K_SHIFT);
      chk("shift_upper", 32'h1, shift_upper);
      press(RKC_K_STOP);
      chk("shift_upper", 32'h0, shift_upper);
      chk("motor_stop", 32'h1, motor_stop);
      tick(PC);
      chk("motor_stop", 32'h0, motor_stop);
      press(RKC_K_SHIFT);
      tick(SC);
      chk("shift_upper", 32'h0, shift_upper);
      // Shift and stop together must not count as a shifted stop.
      keys <= 9'h102;
      tick(3);
      keys <= 9'h0;
      tick(3);
      chk("motor_stop", 32'h0, motor_stop);
   endtask : t_stop
   task automatic t_motor;
      press(RKC_K_SHIFT);
      keys[RKC_K_START] <= 1'b1;
      tick(4);
      chk("motor_start", 32'h1, motor_start);
      chk("speed", `RKC_IDLE_RESET, engine_speed);
      keys[RKC_K_START] <= 1'b0;
      tick(3);
      chk("motor_start", 32'h0, motor_start);
      press(RKC_K_ESTOP);
      chk("motor_stop", 32'h1, motor_stop);
      tick(PC);
      flow_switch <= 1'b0;
      keys[RKC_K_UP] <= 1'b1;
      tick(12);
      keys[RKC_K_UP] <= 1'b0;
      chk("speed", `RKC_IDLE_RESET, engine_speed);
   endtask : t_motor
   task automatic t_preset;
      want_scr <= 1'b1;
      tick(3);
      chk("preset_screen", 32'h1, preset_screen);
      press(RKC_K_VUP);
      chk("preset", `RKC_PRESET_RESET + `RKC_PRESET_SMALL, preset_volume);
      chk("host_preset", `RKC_PRESET_RESET + `RKC_PRESET_SMALL, rx_preset);
      press(RKC_K_SHIFT);
      press(RKC_K_VDN);
      chk("preset", `RKC_PRESET_RESET + `RKC_PRESET_SMALL - `RKC_PRESET_LARGE, preset_volume);
      tick(14);
      chk("shift_upper", 32'h1, shift_upper);
      press(RKC_K_SHIFT);
      chk("shift_upper", 32'h0, shift_upper);
      press(RKC_K_VDN);
      rd(`RKC_OFS_PRESET, `RKC_PRESET_RESET - `RKC_PRESET_LARGE);
      chk("host_preset", `RKC_PRESET_RESET - `RKC_PRESET_LARGE, rx_preset);
   endtask : t_preset
   initial begin
      tick(2);
      aresetn <= 1'b1;
      tick(1);
      chk("speed", `RKC_IDLE_RESET, engine_speed);
      chk("preset", `RKC_PRESET_RESET, preset_volume);
      t_menu();
      t_stop();
      t_motor();
      t_preset();
      close_out();
   end
endmodule : rkc_remote_keys_bench
